// File: common/dmapg_defs.svh
/*
 * Constants of the DMA ping-pong / scatter-gather channel sequencer:
 * control-table layout, control-word fields, mode codes and register offsets.
 * Assumes a byte-addressed 32-bit system memory bus.
 */
`ifndef DMAPG_DEFS_SVH
`define DMAPG_DEFS_SVH

// control structure layout inside one 16-byte entry
`define DMAPG_OFS_SRC_END 4'h0
`define DMAPG_OFS_DST_END 4'h4
`define DMAPG_OFS_CTL 4'h8
`define DMAPG_STRUCT_SHIFT 4
`define DMAPG_ALT_OFS 10'h200
`define DMAPG_BASE_ZERO 10'h000
`define DMAPG_WORD_STEP 4'h4

// control word fields
`define DMAPG_F_DSTINC 31:30
`define DMAPG_F_DSTSIZE 29:28
`define DMAPG_F_SRCINC 27:26
`define DMAPG_F_SRCSIZE 25:24
`define DMAPG_F_HIGH 31:14
`define DMAPG_F_CNT 13:4
`define DMAPG_F_BURST 3
`define DMAPG_F_MODE 2:0

// transfer modes
`define DMAPG_M_STOP 3'h0
`define DMAPG_M_BASIC 3'h1
`define DMAPG_M_AUTO 3'h2
`define DMAPG_M_PINGPONG 3'h3
`define DMAPG_M_MSG_PRI 3'h4
`define DMAPG_M_MSG_ALT 3'h5
`define DMAPG_M_PSG_PRI 3'h6
`define DMAPG_M_PSG_ALT 3'h7

// sizes and increments
`define DMAPG_SIZE_WORD 2'h2
`define DMAPG_INC_NONE 2'h3
`define DMAPG_CNT_ZERO 10'h000
`define DMAPG_CNT_ONE 10'h001
`define DMAPG_FETCH_LAST 2'h2
`define DMAPG_COPY_LAST 2'h3

// register map (byte offsets)
`define DMAPG_REG_BASE 8'h00
`define DMAPG_REG_CTRL 8'h04
`define DMAPG_REG_SWREQ 8'h08
`define DMAPG_REG_STATUS 8'h0C
`define DMAPG_CTRL_EN 0
`define DMAPG_CTRL_ALT 1
`define DMAPG_SWREQ_BIT 0
`define DMAPG_BASE_LSB 10

`endif

// File: common/dmapg_pkg.sv
/*
 * Types shared by the channel sequencer files.
 * Assumes dmapg_defs.svh is on the include path.
 */
package dmapg_pkg;
	typedef enum logic [2:0] {st_idle, st_fetch, st_check, st_read, st_write, st_wback, st_next} dmapg_state_t;
	typedef enum logic [1:0] {end_pause, end_copy, end_done} dmapg_end_t;
	typedef logic [2:0] dmapg_mode_t;
endpackage

// File: rtl/dmapg_addr.sv
/*
 * Element address from an inclusive end pointer, the remaining-count field
 * and the increment code. Assumes count holds items left minus one.
 */
`timescale 1ns/1ns
`include "dmapg_defs.svh"

module dmapg_addr
	import dmapg_pkg::*;
(
	// structure fields
	input wire logic [31:0] end_ptr,
	input wire logic [9:0] count,
	input wire logic [1:0] inc,
	// element address
	output logic [31:0] addr
);
	// fixed address keeps the end pointer; otherwise step back from the end
	wire [31:0] back = {22'h000000, count} << inc;
	assign addr = (inc == `DMAPG_INC_NONE) ? end_ptr : end_ptr - back;
endmodule

// File: rtl/dmapg_chan.sv
/*
 * One DMA channel sequencer: ping-pong, memory and peripheral scatter-gather,
 * basic and auto runs, reading its control structures from system memory.
 * Assumes a memory slave that answers each held request with a one-cycle ack,
 * and a peripheral request on the same clock.
 */
// Design decisions made here: the plain strobed port and the register addresses.
// Overview of operation
// - ping-pong uses both structures, starting with the primary one.
// - primary done in ping-pong fetches alternate and continues without software.
// - each ping-pong switch pulses an event; software reloads the finished structure.
// - ping-pong keeps alternating while software keeps reloading structures.
// - memory scatter-gather primary copies list entries into the alternate structure.
// - copy one entry per phase, alternating copy and execute phases.
// - a basic-mode entry ends the list; channel stops after it.
// - completion event only after the final task, never intermediate ones.
// - a last entry rewriting the primary structure loops the list.
// - software trigger writes count as normal channel requests.
// - one request runs a whole memory scatter-gather list.
// - each peripheral request copies one entry then runs that transfer.
// - peripheral scatter-gather waits for a fresh request between tasks.
// - element sizes of byte, half-word and word.
// - independent source and destination increments, or fixed address.
// - structures are 16 bytes: source end, destination end, control, unused.
// - primaries fill the first table half, alternates start at 0x200.
// - control word written back; completion leaves count zero and stop mode.
// - basic mode outside a list run moves items only while a request is present, then stops.
`timescale 1ns/1ns
`include "dmapg_defs.svh"

module dmapg_chan
	import dmapg_pkg::*;
#(
	parameter int CHAN = 0
)
(
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// system memory bus master
	output logic mem_req,
	output logic mem_we,
	output logic [31:0] mem_addr,
	output logic [1:0] mem_size,
	output logic [31:0] mem_wdata,
	input wire logic mem_ack,
	input wire logic [31:0] mem_rdata,
	// peripheral request and events
	input wire logic dma_req,
	output logic done_pulse,
	output logic switch_pulse,
	output logic chan_active
);
	localparam logic [9:0] CHAN_OFS = 10'(CHAN << `DMAPG_STRUCT_SHIFT);

	dmapg_state_t state;
	dmapg_end_t end_kind;
	dmapg_mode_t mode;
	logic [21:0] tbl_base;
	logic chan_en;
	logic alt_sel;
	logic running;
	logic sw_pend;
	logic [1:0] fidx;
	logic [1:0] copies;
	logic [31:0] src_end;
	logic [31:0] dst_end;
	logic [31:0] ctl;
	logic [9:0] cnt;
	logic [31:0] elem;

	// register decode
	wire wr_base = reg_wr && (reg_addr == `DMAPG_REG_BASE);
	wire wr_ctrl = reg_wr && (reg_addr == `DMAPG_REG_CTRL);
	wire wr_swreq = reg_wr && (reg_addr == `DMAPG_REG_SWREQ) && reg_wdata[`DMAPG_SWREQ_BIT];
	wire busy = (state != st_idle);
	wire [31:0] status_word = {12'h000, busy, running, alt_sel, chan_en, 2'h0, cnt, 1'b0, mode};
	wire [31:0] ctrl_word = {30'h00000000, alt_sel, chan_en};
	wire [31:0] rd_mux = (reg_addr == `DMAPG_REG_BASE) ? {tbl_base, `DMAPG_BASE_ZERO} :
		(reg_addr == `DMAPG_REG_CTRL) ? ctrl_word :
		(reg_addr == `DMAPG_REG_STATUS) ? status_word : 32'h00000000;

	// a software trigger is just another request to the channel
	wire req_in = dma_req || sw_pend;

	// structure base: primaries in the lower half, alternates above
	wire [9:0] half_ofs = alt_sel ? `DMAPG_ALT_OFS : `DMAPG_BASE_ZERO;
	wire [31:0] struct_addr = {tbl_base, half_ofs | CHAN_OFS};
	wire [31:0] fetch_addr = struct_addr + {28'h0000000, fidx, 2'h0};
	wire [31:0] ctl_addr = struct_addr + {28'h0000000, `DMAPG_OFS_CTL};

	// mode decoding of the fetched control word
	wire [2:0] f_mode = ctl[`DMAPG_F_MODE];
	wire is_sg_pri = (mode == `DMAPG_M_MSG_PRI) || (mode == `DMAPG_M_PSG_PRI);
	// basic and ping-pong move one item per present request; inside a run they finish
	wire need_req = ((mode == `DMAPG_M_BASIC) || (mode == `DMAPG_M_PINGPONG)) && !running;
	wire last_elem = (cnt == `DMAPG_CNT_ZERO);
	wire copy_full = is_sg_pri && (copies == `DMAPG_COPY_LAST);
	// start condition: memory runs continue on their own, others need a request
	wire go = chan_en && (req_in || running);

	// element addresses; size comes from the source field only
	wire [31:0] src_addr;
	wire [31:0] dst_addr;
	wire [1:0] elem_size = ctl[`DMAPG_F_SRCSIZE];
	// a copy phase only ever lands in the four words of the alternate structure,
	// so its destination steps by the word index within the entry, not the whole count
	wire [9:0] dst_cnt = is_sg_pri ? {8'h00, cnt[1:0]} : cnt;

	dmapg_addr u_src
	(
		.end_ptr(src_end),
		.count(cnt),
		.inc(ctl[`DMAPG_F_SRCINC]),
		.addr(src_addr)
	);

	dmapg_addr u_dst
	(
		.end_ptr(dst_end),
		.count(dst_cnt),
		.inc(ctl[`DMAPG_F_DSTINC]),
		.addr(dst_addr)
	);

	// control word written back: completion leaves count zero and stop
	wire [2:0] wb_mode = (end_kind == end_pause) ? mode : `DMAPG_M_STOP;
	wire [31:0] wb_word = (end_kind == end_copy && !last_elem) ?
		{ctl[`DMAPG_F_HIGH], cnt, ctl[`DMAPG_F_BURST], mode} :
		{ctl[`DMAPG_F_HIGH], cnt, ctl[`DMAPG_F_BURST], wb_mode};

	// register read data stands for one cycle only
	always_ff @(posedge mclk)
	begin
		if (reset)
			reg_rdata <= 32'h00000000;
		else
			reg_rdata <= reg_rd ? rd_mux : 32'h00000000;
	end

	// table base, written by software only
	always_ff @(posedge mclk)
	begin
		if (reset)
			tbl_base <= 22'h000000;
		else if (wr_base)
			tbl_base <= reg_wdata[31:`DMAPG_BASE_LSB];
	end

	// pending software request: a new write wins over consumption
	always_ff @(posedge mclk)
	begin
		if (reset)
			sw_pend <= 1'b0;
		else if (wr_swreq)
			sw_pend <= 1'b1;
		else if (state == st_read && !mem_req)
			sw_pend <= 1'b0;
	end

	// main sequencer
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			state <= st_idle;
			end_kind <= end_pause;
			mode <= `DMAPG_M_STOP;
			chan_en <= 1'b0;
			alt_sel <= 1'b0;
			running <= 1'b0;
			fidx <= 2'h0;
			copies <= 2'h0;
			src_end <= 32'h00000000;
			dst_end <= 32'h00000000;
			ctl <= 32'h00000000;
			cnt <= `DMAPG_CNT_ZERO;
			elem <= 32'h00000000;
			mem_req <= 1'b0;
			mem_we <= 1'b0;
			mem_addr <= 32'h00000000;
			mem_size <= `DMAPG_SIZE_WORD;
			mem_wdata <= 32'h00000000;
			done_pulse <= 1'b0;
			switch_pulse <= 1'b0;
			chan_active <= 1'b0;
		end
		else
		begin
			done_pulse <= 1'b0;
			switch_pulse <= 1'b0;
			chan_active <= busy;
			// software enable and structure select; only taken while idle
			if (wr_ctrl && state == st_idle)
			begin
				chan_en <= reg_wdata[`DMAPG_CTRL_EN];
				alt_sel <= reg_wdata[`DMAPG_CTRL_ALT];
				if (!reg_wdata[`DMAPG_CTRL_EN])
					running <= 1'b0;
			end
			case (state)
				st_idle:
				begin
					fidx <= 2'h0;
					if (go && !wr_ctrl)
						state <= st_fetch;
				end
				// read source end, destination end, control word
				st_fetch:
				begin
					if (!mem_req)
					begin
						mem_req <= 1'b1;
						mem_we <= 1'b0;
						mem_size <= `DMAPG_SIZE_WORD;
						mem_addr <= fetch_addr;
					end
					else if (mem_ack)
					begin
						mem_req <= 1'b0;
						fidx <= fidx + 2'h1;
						if (fidx == 2'h0)
							src_end <= mem_rdata;
						else if (fidx == 2'h1)
							dst_end <= mem_rdata;
						else
							ctl <= mem_rdata;
						if (fidx == `DMAPG_FETCH_LAST)
							state <= st_check;
					end
				end
				st_check:
				begin
					mode <= f_mode;
					cnt <= ctl[`DMAPG_F_CNT];
					copies <= 2'h0;
					// stop mode: channel disables itself, run ends here
					if (f_mode == `DMAPG_M_STOP)
					begin
						chan_en <= 1'b0;
						running <= 1'b0;
						done_pulse <= running;
						state <= st_idle;
					end
					else
					begin
						// auto and memory lists keep going without new requests
						if (f_mode == `DMAPG_M_AUTO || f_mode == `DMAPG_M_MSG_PRI)
							running <= 1'b1;
						// a peripheral list entry is fetched only on request, then run
						if (f_mode == `DMAPG_M_PSG_PRI || f_mode == `DMAPG_M_PSG_ALT)
							running <= 1'b1;
						state <= st_read;
					end
				end
				// read one element from the source
				st_read:
				begin
					if (!mem_req)
					begin
						if (need_req && !req_in)
						begin
							end_kind <= end_pause;
							state <= st_wback;
						end
						else
						begin
							mem_req <= 1'b1;
							mem_we <= 1'b0;
							mem_size <= is_sg_pri ? `DMAPG_SIZE_WORD : elem_size;
							mem_addr <= src_addr;
						end
					end
					else if (mem_ack)
					begin
						mem_req <= 1'b0;
						elem <= mem_rdata;
						state <= st_write;
					end
				end
				// write it to the destination; a copy phase lands in the alternate
				st_write:
				begin
					if (!mem_req)
					begin
						mem_req <= 1'b1;
						mem_we <= 1'b1;
						mem_addr <= dst_addr;
						mem_wdata <= elem;
					end
					else if (mem_ack)
					begin
						mem_req <= 1'b0;
						mem_we <= 1'b0;
						copies <= copies + 2'h1;
						if (last_elem)
						begin
							end_kind <= is_sg_pri ? end_copy : end_done;
							state <= st_wback;
						end
						else
						begin
							cnt <= cnt - `DMAPG_CNT_ONE;
							if (copy_full)
							begin
								end_kind <= end_copy;
								state <= st_wback;
							end
							else
								state <= st_read;
						end
					end
				end
				// write back count and mode of the active structure
				st_wback:
				begin
					if (!mem_req)
					begin
						mem_req <= 1'b1;
						mem_we <= 1'b1;
						mem_size <= `DMAPG_SIZE_WORD;
						mem_addr <= ctl_addr;
						mem_wdata <= wb_word;
					end
					else if (mem_ack)
					begin
						mem_req <= 1'b0;
						mem_we <= 1'b0;
						state <= st_next;
					end
				end
				// choose what follows the finished phase
				st_next:
				begin
					fidx <= 2'h0;
					state <= st_fetch;
					if (end_kind == end_pause)
						state <= st_idle;
					else if (end_kind == end_copy)
						alt_sel <= 1'b1;
					else
					begin
						case (mode)
							`DMAPG_M_PINGPONG:
							begin
								alt_sel <= !alt_sel;
								switch_pulse <= 1'b1;
							end
							`DMAPG_M_MSG_ALT:
								alt_sel <= 1'b0;
							`DMAPG_M_PSG_ALT:
							begin
								alt_sel <= 1'b0;
								running <= 1'b0;
								state <= st_idle;
							end
							default:
							begin
								// basic or auto: final transfer, list end included
								chan_en <= 1'b0;
								running <= 1'b0;
								alt_sel <= 1'b0;
								done_pulse <= 1'b1;
								state <= st_idle;
							end
						endcase
					end
				end
				default:
					state <= st_idle;
			endcase
		end
	end
endmodule

// File: testbench/dmapg_chan_properties.sv
/* Port checks of the channel sequencer.
   Assumes one clock domain; bound to dmapg_chan below. */
`timescale 1ns/1ns
module dmapg_chan_properties (
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// register port
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	// memory bus
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [31:0] mem_addr,
	input wire logic [1:0] mem_size,
	input wire logic [31:0] mem_wdata,
	input wire logic mem_ack,
	// events
	input wire logic done_pulse,
	input wire logic switch_pulse
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (reset);
	// a request still waiting, and one that got its ack
	sequence s_wait;
		mem_req && !mem_ack;
	endsequence
	sequence s_grant;
		mem_req && mem_ack;
	endsequence
	a_req_held: assert property (s_wait |=> mem_req && $stable(mem_addr) && $stable(mem_we)
		&& $stable(mem_size) && $stable(mem_wdata)) else $error("request moved before ack");
	a_req_drop: assert property (s_grant |=> !mem_req) else $error("no idle cycle after ack");
	a_done_single: assert property (done_pulse |=> !done_pulse) else $error("done too long");
	a_switch_single: assert property (switch_pulse |=> !switch_pulse) else $error("switch too long");
	a_pulse_apart: assert property (!(done_pulse && switch_pulse)) else $error("done with switch");
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0) else $error("stray read data");
	a_size_legal: assert property (mem_req |-> mem_size != 2'h3) else $error("bad size");
	a_addr_aligned: assert property (mem_req |-> (mem_addr & ((32'h1 << mem_size) - 32'h1)) == 32'h0)
		else $error("misaligned access");
endmodule
bind dmapg_chan dmapg_chan_properties u_props (.mclk(mclk), .reset(reset), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_size(mem_size),
	.mem_wdata(mem_wdata), .mem_ack(mem_ack), .done_pulse(done_pulse), .switch_pulse(switch_pulse));

// File: testbench/dmapg_mem.sv
/* Byte memory on the channel bus, acking after lat wait cycles.
   Assumes 4 KiB of address space; the bench loads m directly. */
`timescale 1ns/1ns
module dmapg_mem (
	// clock and wait setting
	input wire logic mclk,
	input wire logic [2:0] lat,
	// bus from the channel
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [31:0] mem_addr,
	input wire logic [1:0] mem_size,
	input wire logic [31:0] mem_wdata,
	output logic mem_ack,
	output logic [31:0] mem_rdata
);
	logic [7:0] m [0:4095];
	logic [11:0] a;
	int w = 0;
	assign a = mem_addr[11:0];
	initial
	begin
		mem_ack = 1'b0;
		mem_rdata = 32'h0;
	end
	// read data is garbage outside the ack cycle, so late sampling shows up
	always @(posedge mclk)
	begin
		mem_ack <= 1'b0;
		mem_rdata <= ~mem_rdata;
		if (mem_req === 1'b1 && !mem_ack && w < lat)
			w <= w + 1;
		else if (mem_req === 1'b1 && !mem_ack)
		begin
			w <= 0;
			mem_ack <= 1'b1;
			mem_rdata <= {m[a + 3], m[a + 2], m[a + 1], m[a]};
			for (int k = 0; k < (1 << mem_size); k++)
				if (mem_we)
					m[a + k] <= mem_wdata[8 * k +: 8];
		end
	end
endmodule

// File: testbench/dma_pingpong_scatter_gather_tb.sv
/* Bench for the channel sequencer: registers, ping-pong, memory and peripheral lists.
   Assumes dmapg_mem as system memory, table base 0x800, channel 0. */
`timescale 1ns/1ns
`include "dmapg_defs.svh"
module dma_pingpong_scatter_gather_tb;
	logic mclk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, dma_req = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [2:0] lat = 3'h0;
	logic [31:0] reg_wdata = 32'h0, reg_rdata, mem_addr, mem_wdata, mem_rdata, rv, m;
	logic mem_req, mem_we, mem_ack, done_pulse, switch_pulse, chan_active;
	logic [1:0] mem_size;
	logic [31:0] c [0:8];
	logic [7:0] sh [0:4095];
	int num_errors = 0, checked = 0, n_done = 0, n_sw = 0, n_ack = 0, seed = 32'h0237, i;
	localparam logic [31:0] KEEP = 32'hFFFF_C008;
	always #25 mclk = ~mclk;
	dmapg_chan u_dut (.mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
		.mem_size(mem_size), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
		.dma_req(dma_req), .done_pulse(done_pulse), .switch_pulse(switch_pulse), .chan_active(chan_active));
	dmapg_mem u_mem (.mclk(mclk), .lat(lat), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
		.mem_size(mem_size), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
	// event tallies at the ports
	always @(posedge mclk)
	begin
		n_done += int'(done_pulse === 1'b1);
		n_sw += int'(switch_pulse === 1'b1);
		n_ack += int'(mem_ack === 1'b1);
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic test_done();
		if (num_errors == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// register accesses, entered just after a rising edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
		// let one edge pass so a following write never sets the strobe in the same step
		@(posedge mclk);
	endtask
	task automatic rd(input logic [7:0] a);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		@(posedge mclk);
		rv = reg_rdata;
	endtask
	function automatic logic [31:0] get(input int a, input bit shadow);
		if (shadow)
			return {sh[a + 3], sh[a + 2], sh[a + 1], sh[a]};
		return {u_mem.m[a + 3], u_mem.m[a + 2], u_mem.m[a + 1], u_mem.m[a]};
	endfunction
	function automatic logic [31:0] cw(input logic [1:0] di, sz, si, input int n, input logic [2:0] md);
		return {di, sz, si, sz, 10'h000, 10'(n - 1), 1'b0, md};
	endfunction
	// one structure written to memory and to the shadow alike
	task automatic stx(input int sa, input int se, input int de, input logic [31:0] cv);
		logic [95:0] s;
		s = {cv, de[31:0], se[31:0]};
		for (int k = 0; k < 12; k++)
		begin
			sh[sa + k] = s[8 * k +: 8];
			u_mem.m[sa + k] = s[8 * k +: 8];
		end
	endtask
	// expected effect of one transfer, addressed back from the inclusive end pointers
	task automatic xfer(input int se, input int de, input logic [31:0] cv);
		int n, r;
		n = int'(cv[13:4]) + 1;
		for (int e = 0; e < n; e++)
		begin
			r = n - 1 - e;
			for (int k = 0; k < (1 << cv[25:24]); k++)
				sh[de - (cv[31:30] == 2'h3 ? 0 : r << cv[31:30]) + k] = sh[se - (cv[27:26] == 2'h3 ? 0 : r << cv[27:26]) + k];
		end
	endtask
	task automatic settle();
		i = 0;
		while (chan_active !== 1'b1 && i++ < 40)
			@(posedge mclk);
		while (chan_active !== 1'b0 && i++ < 4000)
			@(posedge mclk);
	endtask
	task automatic cmp_data();
		for (int a = 0; a < 1024; a += 4)
			check("data", get(a, 0), get(a, 1));
	endtask
	// hang guard at 20000 cycles, more than ten times the cycles the run needs
	initial
	begin
		#(50 * 20000);
		num_errors++;
		test_done();
	end
	initial
	begin
		for (i = 0; i < 4096; i++)
		begin
			sh[i] = 8'($random(seed));
			u_mem.m[i] = sh[i];
		end
		repeat (5) @(posedge mclk);
		reset <= 1'b0;
		@(posedge mclk);
		rd(`DMAPG_REG_STATUS);
		check("status", rv, 32'h0);
		wr(`DMAPG_REG_BASE, 32'hFFFF_FFFF);
		rd(`DMAPG_REG_BASE);
		check("base", rv, 32'hFFFF_FC00);
		rd(8'h10);
		check("unmapped", rv, 32'h0);
		wr(`DMAPG_REG_BASE, 32'h0000_0800);
		// ping-pong: halfword primary, then word alternate from a fixed source
		lat <= 3'($random(seed));
		c[0] = cw(2'h1, 2'h1, 2'h1, 3, `DMAPG_M_PINGPONG);
		c[1] = cw(2'h2, 2'h2, 2'h3, 2, `DMAPG_M_PINGPONG);
		stx(32'h800, 32'h10E, 32'h20E, c[0]);
		stx(32'hA00, 32'h13C, 32'h23C, c[1]);
		dma_req <= 1'b1;
		wr(`DMAPG_REG_CTRL, 32'h1);
		settle();
		dma_req <= 1'b0;
		xfer(32'h10E, 32'h20E, c[0]);
		xfer(32'h13C, 32'h23C, c[1]);
		check("switches", n_sw, 2);
		check("pp done", n_done, 0);
		check("pri ctl", get(32'h808, 0), c[0] & KEEP);
		check("alt ctl", get(32'hA08, 0), c[1] & KEEP);
		rd(`DMAPG_REG_STATUS);
		check("pp halted", {30'h0, rv[17:16]}, 32'h0);
		cmp_data();
		// memory list: byte items to word-spaced slots, then a basic entry ends it
		lat <= 3'($random(seed));
		n_sw = 0;
		c[2] = cw(2'h2, 2'h0, 2'h0, 4, `DMAPG_M_MSG_ALT);
		c[3] = cw(2'h2, 2'h2, 2'h3, 2, `DMAPG_M_BASIC);
		c[4] = cw(2'h2, 2'h2, 2'h2, 8, `DMAPG_M_MSG_PRI);
		stx(32'h600, 32'h303, 32'h33C, c[2]);
		stx(32'h610, 32'h350, 32'h36C, c[3]);
		stx(32'h800, 32'h61C, 32'hA0C, c[4]);
		wr(`DMAPG_REG_CTRL, 32'h1);
		wr(`DMAPG_REG_SWREQ, 32'h1);
		settle();
		xfer(32'h303, 32'h33C, c[2]);
		xfer(32'h350, 32'h36C, c[3]);
		check("msg done", n_done, 1);
		check("msg switch", n_sw, 0);
		check("msg pri", get(32'h808, 0), c[4] & KEEP);
		check("msg alt", get(32'hA08, 0), c[3] & KEEP);
		cmp_data();
		// peripheral list: one entry per request, nothing while the request is low
		lat <= 3'($random(seed));
		n_done = 0;
		c[5] = cw(2'h2, 2'h2, 2'h2, 2, `DMAPG_M_PSG_ALT);
		c[6] = cw(2'h3, 2'h1, 2'h1, 2, `DMAPG_M_PSG_ALT);
		c[7] = cw(2'h2, 2'h2, 2'h2, 1, `DMAPG_M_BASIC);
		c[8] = cw(2'h2, 2'h2, 2'h2, 12, `DMAPG_M_PSG_PRI);
		stx(32'h700, 32'h384, 32'h3A4, c[5]);
		stx(32'h710, 32'h3B2, 32'h3C0, c[6]);
		stx(32'h720, 32'h3D0, 32'h3E0, c[7]);
		stx(32'h800, 32'h72C, 32'hA0C, c[8]);
		wr(`DMAPG_REG_CTRL, 32'h1);
		for (int t = 0; t < 3; t++)
		begin
			m = n_ack;
			repeat (20) @(posedge mclk);
			check("idle acks", n_ack, m);
			dma_req <= 1'b1;
			i = 0;
			while (chan_active !== 1'b1 && i++ < 40)
				@(posedge mclk);
			dma_req <= 1'b0;
			settle();
			check("psg done", n_done, t / 2);
		end
		xfer(32'h384, 32'h3A4, c[5]);
		xfer(32'h3B2, 32'h3C0, c[6]);
		xfer(32'h3D0, 32'h3E0, c[7]);
		check("psg pri", get(32'h808, 0), c[8] & KEEP);
		cmp_data();
		test_done();
	end
endmodule
